// ### rtl/pcm_connection_manager.sv
// physical connection manager with its AXI4-Lite register slave
// How it works
// - start code begins the connection machine, stop code returns it to OFF
// - status register B shows the current connection state
// - line state, receive code and transmit code flags are readable status
// - enabled event set only in ACTIVE after scrubbing completes
// - BREAK, CONNECT, NEXT, then NEXT and SIGNAL alternate once per bit
// - Master line state sends zero, Halt line state sends one
// - each received bit is collected into the incoming bits register
// - after the last bit, set done event and stay in NEXT
// - after a break not caused by start, wait for a new start
// - every break entry raises break event and records its cause
// - up to 16 bits per sequence, first 10 are standard
// - confidence test ends on duration, Halt or Master, then done event
// - reloading count and bits signals again and sets done again
// - join command in NEXT moves the machine to JOIN
// - join ignored outside NEXT or while signalling is in progress
// - join during confidence test aborts the test and joins
// - noise timer loads limit when leaving idle, counts until idle
// - noise expiry in ACTIVE breaks the link unless trace is set, ignored elsewhere
// - in ACTIVE noise counting waits for the line state flag
// - trace command with noise expiry in one cycle goes to BREAK; the trace bit only acts from the next cycle
// - reset or stop enters OFF; start or maintenance bit leaves it
`timescale 1ns/100ps
`default_nettype none
module pcm_connection_manager
  import pcm_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // line side
  input  wire line_state_t rxLineState,
  input  wire logic        lineStateFlag,
  output line_state_t      txLineState,
  // insertion side
  input  wire logic        scrubDone,
  output logic             scJoin
);
  typedef struct packed {
    pcm_state_t    state;
    break_cause_t  cause;
    line_state_t   tx;
    logic [1:0]    cmd;
    logic          trace;
    logic          maint;
    logic          extTest;
    logic [3:0]    sigCount;
    logic [15:0]   outBits;
    logic [15:0]   inBits;
    logic [15:0]   minBreak;
    logic [15:0]   minLsTx;
    logic [15:0]   lctLen;
    logic [15:0]   noiseLimit;
    logic [EV_W-1:0] events;
    logic          armed;
    logic          vecLoaded;
    logic          signaling;
    logic          lctRun;
    logic          receive_code_flag;
    logic          transmit_code_flag;
    logic [3:0]    bitIdx;
    logic [TMR_W-1:0] tmr;
    logic          haveAw;
    logic [7:0]    awAddr;
    logic          haveW;
    logic [31:0]   wData;
    logic [3:0]    wStrb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
  } pcm_regs_t;

  pcm_regs_t        st;
  pcm_regs_t        next_st;
  pcm_state_t       next_state;
  break_cause_t     brkCause;
  logic             brk;
  logic             wrStart;
  logic             wrStop;
  logic             wrJoin;
  logic             wrResume;
  logic             sigDone;
  logic [EV_W-1:0]  evSet;
  logic [EV_W-1:0]  evClr;
  noise_if          nt ();

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic line_state_t txFor(input pcm_state_t s, input logic b);
    case (s)
      S_CONNECT, S_JOIN:           txFor = LS_HALT;
      S_SIGNAL:                    txFor = b ? LS_HALT : LS_MASTER;
      S_VERIFY, S_TRACE:           txFor = LS_MASTER;
      S_NEXT, S_ACTIVE, S_MAINT:   txFor = LS_IDLE;
      default:                     txFor = LS_QUIET;
    endcase
  endfunction

  pcm_noise_timer u_noise (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clkEn   (clkEn),
    .nt      (nt)
  );

  assign nt.limit   = st.noiseLimit;
  // held idle outside ACTIVE: an expiry left over from JOIN or VERIFY must not break the link on entry
  assign nt.idleNow = (rxLineState == LS_IDLE) || (st.state != S_ACTIVE);
  // outside ACTIVE the expiry is never looked at, so gating only matters there
  assign nt.countEn = (st.state != S_ACTIVE) || lineStateFlag;

  always_comb begin
    next_st  = st;
    wrStart  = 1'b0;
    wrStop   = 1'b0;
    wrJoin   = 1'b0;
    wrResume = 1'b0;
    sigDone  = 1'b0;
    brk      = 1'b0;
    brkCause = BC_NONE;
    evSet    = '0;
    evClr    = '0;
    // write address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.haveAw = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.haveW = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.haveAw && st.haveW) begin
      next_st.haveAw = 1'b0;
      next_st.haveW  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = RESP_OKAY;
      case (st.awAddr)
        ADDR_CTRL_B: begin
          if (st.wStrb[0]) begin
            next_st.cmd     = st.wData[CMD_LO +: 2];
            next_st.trace   = st.wData[TRACE_BIT];
            next_st.maint   = st.wData[MAINT_BIT];
            next_st.extTest = st.wData[EXT_BIT];
            wrStart  = (st.wData[CMD_LO +: 2] == CMD_START);
            wrStop   = (st.wData[CMD_LO +: 2] == CMD_STOP);
            wrJoin   = st.wData[JOIN_BIT];
            wrResume = st.wData[RESUME_BIT];
          end
        end
        ADDR_EVENT:     evClr = st.wStrb[0] ? st.wData[EV_W-1:0] : '0;
        ADDR_SIG_COUNT: next_st.sigCount = st.wStrb[0] ? st.wData[3:0] : st.sigCount;
        ADDR_OUT_BITS: begin
          // loading the pattern arms a fresh signalling run from bit zero
          next_st.outBits   = merge16(st.outBits, st.wData, st.wStrb);
          next_st.vecLoaded = 1'b1;
          next_st.signaling = 1'b1;
          next_st.bitIdx    = '0;
          next_st.receive_code_flag       = 1'b0;
          next_st.transmit_code_flag       = 1'b0;
        end
        ADDR_MIN_BREAK: next_st.minBreak   = merge16(st.minBreak, st.wData, st.wStrb);
        ADDR_MIN_LS_TX: next_st.minLsTx    = merge16(st.minLsTx, st.wData, st.wStrb);
        ADDR_LCT_LEN:   next_st.lctLen     = merge16(st.lctLen, st.wData, st.wStrb);
        ADDR_NOISE_LIM: next_st.noiseLimit = merge16(st.noiseLimit, st.wData, st.wStrb);
        ADDR_STATUS_B, ADDR_IN_BITS: ;
        default:        next_st.bresp = RESP_SLVERR;
      endcase
    end
    // read side
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = RESP_OKAY;
      next_st.rdata  = '0;
      case (s_axi_araddr)
        ADDR_CTRL_B: begin
          next_st.rdata[CMD_LO +: 2] = st.cmd;
          next_st.rdata[TRACE_BIT]   = st.trace;
          next_st.rdata[MAINT_BIT]   = st.maint;
          next_st.rdata[EXT_BIT]     = st.extTest;
        end
        ADDR_STATUS_B: begin
          next_st.rdata[ST_STATE_LO +: 4] = st.state;
          next_st.rdata[ST_CAUSE_LO +: 3] = st.cause;
          next_st.rdata[ST_LSF]           = lineStateFlag;
          next_st.rdata[ST_RCF]           = st.receive_code_flag;
          next_st.rdata[ST_TCF]           = st.transmit_code_flag;
          next_st.rdata[ST_SIGNALING]     = st.signaling;
        end
        ADDR_EVENT:     next_st.rdata[EV_W-1:0] = st.events;
        ADDR_SIG_COUNT: next_st.rdata[3:0]  = st.sigCount;
        ADDR_OUT_BITS:  next_st.rdata[15:0] = st.outBits;
        ADDR_IN_BITS:   next_st.rdata[15:0] = st.inBits;
        ADDR_MIN_BREAK: next_st.rdata[15:0] = st.minBreak;
        ADDR_MIN_LS_TX: next_st.rdata[15:0] = st.minLsTx;
        ADDR_LCT_LEN:   next_st.rdata[15:0] = st.lctLen;
        ADDR_NOISE_LIM: next_st.rdata[15:0] = st.noiseLimit;
        default:        next_st.rresp = RESP_SLVERR;
      endcase
    end
    // connection machine
    next_state = st.state;
    if (wrStop) begin
      next_state        = S_OFF;
      next_st.armed     = 1'b0;
      next_st.signaling = 1'b0;
      next_st.lctRun    = 1'b0;
    end else if (wrStart && st.state != S_MAINT) begin
      brk           = 1'b1;
      brkCause      = BC_START;
      next_st.armed = 1'b1;
    end else if (rxLineState == LS_QUIET && st.state inside {S_CONNECT, S_NEXT, S_SIGNAL, S_JOIN, S_VERIFY,
                                                             S_ACTIVE, S_TRACE}) begin
      brk      = 1'b1;
      brkCause = BC_QUIET;
    end else begin
      case (st.state)
        S_OFF:     if (st.maint) next_state = S_MAINT;
        // without a fresh start the machine never moves on from BREAK to CONNECT
        S_BREAK:   if (st.armed && st.vecLoaded && st.tmr >= st.minBreak) next_state = S_CONNECT;
        S_CONNECT: if (rxLineState == LS_HALT && st.tmr >= st.minLsTx) next_state = S_NEXT;
        S_NEXT: begin
          if (wrJoin && !st.signaling) begin
            next_state     = S_JOIN;
            next_st.lctRun = 1'b0;
          end else if (st.signaling && st.tmr >= st.minLsTx) begin
            next_state  = S_SIGNAL;
            next_st.transmit_code_flag = 1'b1;
          end else if (st.lctRun && ((!st.extTest && st.tmr >= st.lctLen) || wrResume ||
                                     rxLineState inside {LS_HALT, LS_MASTER})) begin
            next_st.lctRun = 1'b0;
            evSet[EV_CODE] = 1'b1;
          end else if (wrResume && !st.signaling && !st.lctRun) begin
            next_st.lctRun = 1'b1;
            next_st.tmr    = '0;
          end
        end
        S_SIGNAL: begin
          if (st.tmr >= st.minLsTx) begin
            sigDone                    = 1'b1;
            next_state                 = S_NEXT;
            next_st.receive_code_flag                = 1'b1;
            next_st.inBits[st.bitIdx]  = (rxLineState == LS_HALT);
            if (st.bitIdx == st.sigCount) begin
              next_st.signaling = 1'b0;
              next_st.vecLoaded = 1'b0;
              evSet[EV_CODE]    = 1'b1;
            end else begin
              next_st.bitIdx = st.bitIdx + 4'h1;
            end
          end
        end
        S_JOIN:    if (rxLineState == LS_HALT && st.tmr >= st.minLsTx) next_state = S_VERIFY;
        S_VERIFY:  if (st.tmr >= st.minLsTx) next_state = S_ACTIVE;
        S_ACTIVE: begin
          if (nt.expired) begin
            if (st.trace) begin
              next_state = S_TRACE;
            end else begin
              brk      = 1'b1;
              brkCause = BC_NOISE;
            end
          end else if (st.trace) begin
            next_state = S_TRACE;
          end
          if (scrubDone) evSet[EV_ENABLED] = 1'b1;
        end
        S_TRACE, S_MAINT: ;
        default:   next_state = S_OFF;
      endcase
    end
    if (brk) begin
      next_state        = S_BREAK;
      next_st.cause     = brkCause;
      evSet[EV_BREAK]   = 1'b1;
      next_st.vecLoaded = 1'b0;
      next_st.signaling = 1'b0;
      next_st.lctRun    = 1'b0;
      if (brkCause != BC_START) next_st.armed = 1'b0;
    end
    // timers count cycles and restart on every state change
    if (next_state != st.state) begin
      next_st.tmr = '0;
    end else if (!(wrResume && next_st.lctRun && !st.lctRun) && st.tmr != '1) begin
      next_st.tmr = st.tmr + 16'h0001;
    end
    next_st.state  = next_state;
    // a hardware set wins over a same-cycle software clear
    next_st.events = (st.events & ~evClr) | evSet;
    next_st.tx     = txFor(next_state, next_st.outBits[next_st.bitIdx]);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st            <= '0;
      st.minBreak   <= MIN_BREAK_RST;
      st.minLsTx    <= MIN_LS_TX_RST;
      st.lctLen     <= LCT_LEN_RST;
      st.noiseLimit <= NOISE_LIM_RST;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  assign s_axi_awready = !st.haveAw && !st.bvalid;
  assign s_axi_wready  = !st.haveW && !st.bvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign txLineState   = st.tx;
  assign scJoin        = (st.state == S_ACTIVE);

  AST_STOP_OFF: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && wrStop |=> st.state == S_OFF) else $error("stop did not reach OFF");
  AST_STATUS_STATE: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_STATUS_B
    |=> s_axi_rvalid && s_axi_rdata[3:0] == $past(st.state)) else $error("status read shows wrong state");
  AST_TX_BIT: assert property (@(posedge clk_sys) disable iff (rst)
    st.state == S_SIGNAL |-> txLineState == (st.outBits[st.bitIdx] ? LS_HALT : LS_MASTER))
    else $error("signal bit sent with wrong line state");
  AST_CAPTURE: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && sigDone && !wrStart && !wrStop && rxLineState != LS_QUIET
    |=> st.inBits[$past(st.bitIdx)] == $past(rxLineState == LS_HALT)) else $error("received bit not stored");
  AST_DONE_NEXT: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(st.signaling) && st.state == S_NEXT |-> st.events[EV_CODE]) else $error("done event missing");
  AST_BREAK_EVENT: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(st.state) && st.state == S_BREAK |-> st.events[EV_BREAK] && st.cause != BC_NONE)
    else $error("break entry without event");
  AST_NO_RESUME: assert property (@(posedge clk_sys) disable iff (rst)
    st.state == S_BREAK && !st.armed && !wrStart |=> st.state inside {S_BREAK, S_OFF})
    else $error("left break without start");
  AST_JOIN_IGNORED: assert property (@(posedge clk_sys) disable iff (rst)
    wrJoin && st.state != S_JOIN && (st.state != S_NEXT || st.signaling) |=> st.state != S_JOIN)
    else $error("join taken when it must be ignored");
  AST_NOISE_BREAK: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && st.state == S_ACTIVE && nt.expired && !wrStop && !wrStart && rxLineState != LS_QUIET
    |=> st.state == ($past(st.trace) ? S_TRACE : S_BREAK)) else $error("noise expiry mishandled");
  AST_ENABLED_ACTIVE: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(st.events[EV_ENABLED]) |-> $past(st.state) == S_ACTIVE) else $error("enabled outside active");

  COV_ACTIVE: cover property (@(posedge clk_sys) disable iff (rst) st.state == S_ACTIVE);
  COV_SIG_DONE: cover property (@(posedge clk_sys) disable iff (rst) $fell(st.signaling) && st.state == S_NEXT);
  COV_LCT_END: cover property (@(posedge clk_sys) disable iff (rst) $fell(st.lctRun) && st.state == S_NEXT);
  COV_NOISE_BREAK: cover property (@(posedge clk_sys) disable iff (rst) st.cause == BC_NOISE);
endmodule // pcm_connection_manager
`default_nettype wire

// ### rtl/pcm_pkg.sv
// shared constants and types of the physical connection manager
package pcm_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL_B     = 8'h00;
  localparam logic [7:0] ADDR_STATUS_B   = 8'h04;
  localparam logic [7:0] ADDR_EVENT      = 8'h08;
  localparam logic [7:0] ADDR_SIG_COUNT  = 8'h0C;
  localparam logic [7:0] ADDR_OUT_BITS   = 8'h10;
  localparam logic [7:0] ADDR_IN_BITS    = 8'h14;
  localparam logic [7:0] ADDR_MIN_BREAK  = 8'h18;
  localparam logic [7:0] ADDR_MIN_LS_TX  = 8'h1C;
  localparam logic [7:0] ADDR_LCT_LEN    = 8'h20;
  localparam logic [7:0] ADDR_NOISE_LIM  = 8'h24;
  // control_reg_b fields
  localparam int CMD_LO     = 0;
  localparam int JOIN_BIT   = 2;
  localparam int RESUME_BIT = 3;
  localparam int TRACE_BIT  = 4;
  localparam int MAINT_BIT  = 5;
  localparam int EXT_BIT    = 6;
  localparam logic [1:0] CMD_START = 2'h1;
  localparam logic [1:0] CMD_STOP  = 2'h3;
  // status_reg_b fields
  localparam int ST_STATE_LO  = 0;
  localparam int ST_CAUSE_LO  = 4;
  localparam int ST_LSF       = 8;
  localparam int ST_RCF       = 9;
  localparam int ST_TCF       = 10;
  localparam int ST_SIGNALING = 11;
  // event_reg bits
  localparam int EV_CODE    = 0;
  localparam int EV_BREAK   = 1;
  localparam int EV_ENABLED = 2;
  localparam int EV_W       = 3;
  // sizes and reset values
  localparam int MAX_BITS = 16;
  localparam int STD_BITS = 10;
  localparam int TMR_W    = 16;
  localparam logic [15:0] MIN_BREAK_RST = 16'h0100;
  localparam logic [15:0] MIN_LS_TX_RST = 16'h0040;
  localparam logic [15:0] LCT_LEN_RST   = 16'h1000;
  localparam logic [15:0] NOISE_LIM_RST = 16'h0800;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {LS_QUIET, LS_HALT, LS_MASTER, LS_IDLE, LS_ACTIVE, LS_NOISE} line_state_t;
  typedef enum logic [3:0] {S_OFF, S_BREAK, S_TRACE, S_CONNECT, S_NEXT, S_SIGNAL, S_JOIN, S_VERIFY,
                            S_ACTIVE, S_MAINT} pcm_state_t;
  typedef enum logic [2:0] {BC_NONE, BC_START, BC_QUIET, BC_NOISE} break_cause_t;
endpackage

// ### rtl/noise_if.sv
// link between the connection manager and its noise timer
`timescale 1ns/100ps
`default_nettype none
interface noise_if;
  logic [15:0] limit;
  logic        idleNow;
  logic        countEn;
  logic        expired;
  modport owner (output limit, idleNow, countEn, input expired);
  modport timer (input limit, idleNow, countEn, output expired);
endinterface
`default_nettype wire

// ### rtl/pcm_noise_timer.sv
// noise timer: times the gap between idle line states
`timescale 1ns/100ps
`default_nettype none
module pcm_noise_timer
  import pcm_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic clkEn,
  // owner side
  noise_if.timer    nt
);
  typedef struct packed {
    logic              prevIdle;
    logic              running;
    logic              expired;
    logic [TMR_W-1:0]  count;
  } nt_state_t;

  nt_state_t st;
  nt_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.prevIdle = nt.idleNow;
    if (nt.idleNow) begin
      next_st.running = 1'b0;
      next_st.expired = 1'b0;
    end else if (st.prevIdle) begin
      next_st.count   = nt.limit;
      next_st.running = 1'b1;
      next_st.expired = 1'b0;
    end else if (st.running && nt.countEn) begin
      if (st.count == '0) begin
        next_st.expired = 1'b1;
      end else begin
        next_st.count = st.count - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  assign nt.expired = st.expired;
endmodule // pcm_noise_timer
`default_nettype wire

// ### verif/pcm_neighbour.sv
// behavioural neighbour station at the far end of the line
`timescale 1ns/100ps
`default_nettype none
module pcm_neighbour
  import pcm_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // line and scenario control
  input  wire line_state_t txLineState,
  input  wire logic        noiseReq,
  output line_state_t      rxLineState
);
  // mirrors us a cycle late; already in connect, so quiet is answered with halt
  always_ff @(posedge clk_sys) begin
    if (rst || txLineState == LS_QUIET) begin
      rxLineState <= LS_HALT;
    end else if (noiseReq) begin
      rxLineState <= LS_NOISE;
    end else begin
      rxLineState <= txLineState;
    end
  end
endmodule // pcm_neighbour
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench of the physical connection manager
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failCount++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module testbench
  import pcm_pkg::*;
;
  logic        clk_sys = 1'h0, rst = 1'h1, clkEn = 1'h1, scrubDone = 1'h0, lineStateFlag = 1'h0, noiseReq = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, scJoin;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
  line_state_t rxLineState, txLineState;
  int          failCount, checks;
  pcm_connection_manager i_pcm_connection_manager (.clk_sys, .rst, .clkEn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rxLineState, .lineStateFlag, .txLineState, .scrubDone, .scJoin);
  pcm_neighbour i_pcm_neighbour (.clk_sys, .rst, .txLineState, .noiseReq, .rxLineState);
  always #12.5 clk_sys = ~clk_sys;
  // one access; each channel is held until its own handshake edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (n = 0; n < 99; n++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_bvalid || s_axi_rvalid) begin
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        rsp = w ? s_axi_bresp : s_axi_rresp;
        rdv = s_axi_rdata;
        n = 99;
      end
    end
    if (n == 99) failCount++;
  endtask
  task automatic waitReg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    for (n = 0; n < 200; n++) begin
      xfer(1'h0, a, 32'h0);
      if ((rdv & m) === v) n = 200;
    end
    if (n == 200) failCount++;
  endtask
  task automatic bootRegs();
    xfer(1'h0, ADDR_STATUS_B, 32'h0);
    `CHK("state", S_OFF, rdv[3:0])
    xfer(1'h1, 8'h3C, 32'h1);
    `CHK("unmappedResp", RESP_SLVERR, rsp)
    // short timers; break time still leaves room to load the vectors
    xfer(1'h1, ADDR_MIN_BREAK, 32'h20);
    xfer(1'h1, ADDR_MIN_LS_TX, 32'h4);
    xfer(1'h1, ADDR_NOISE_LIM, 32'h4);
    xfer(1'h1, ADDR_LCT_LEN, 32'h10);
  endtask
  task automatic signalBits();
    xfer(1'h1, ADDR_CTRL_B, {30'h0, CMD_START});
    xfer(1'h1, ADDR_SIG_COUNT, 32'h2);
    xfer(1'h1, ADDR_OUT_BITS, 32'h5);
    waitReg(ADDR_EVENT, 32'h1, 32'h1);
    xfer(1'h0, ADDR_IN_BITS, 32'h0);
    `CHK("inBits", 3'h5, rdv[2:0])
    xfer(1'h0, ADDR_STATUS_B, 32'h0);
    `CHK("state", S_NEXT, rdv[3:0])
    `CHK("cause", BC_START, rdv[6:4])
    `CHK("tcf", 1'h1, rdv[ST_TCF])
    `CHK("rcf", 1'h1, rdv[ST_RCF])
    `CHK("signaling", 1'h0, rdv[ST_SIGNALING])
    xfer(1'h0, ADDR_EVENT, 32'h0);
    `CHK("breakEvent", 1'h1, rdv[EV_BREAK])
    xfer(1'h1, ADDR_EVENT, 32'h7);
  endtask
  task automatic resendBits();
    xfer(1'h1, ADDR_SIG_COUNT, 32'h0);
    xfer(1'h1, ADDR_OUT_BITS, 32'h0);
    xfer(1'h1, ADDR_CTRL_B, 32'h4);
    xfer(1'h0, ADDR_STATUS_B, 32'h0);
    `CHK("joinIgnored", 1'h1, rdv[3:0] !== S_JOIN)
    waitReg(ADDR_EVENT, 32'h1, 32'h1);
    xfer(1'h0, ADDR_IN_BITS, 32'h0);
    `CHK("inBit", 1'h0, rdv[0])
    xfer(1'h1, ADDR_EVENT, 32'h7);
  endtask
  // confidence test by duration, then held by the extended bit until resumed
  task automatic lctTest();
    xfer(1'h1, ADDR_CTRL_B, 32'h8);
    xfer(1'h0, ADDR_EVENT, 32'h0);
    `CHK("lctRunning", 1'h0, rdv[EV_CODE])
    waitReg(ADDR_EVENT, 32'h1, 32'h1);
    `CHK("lctTimed", 1'h1, rdv[EV_CODE])
    xfer(1'h1, ADDR_EVENT, 32'h7);
    xfer(1'h1, ADDR_CTRL_B, 32'h48);
    repeat (40) @(posedge clk_sys);
    xfer(1'h0, ADDR_EVENT, 32'h0);
    `CHK("lctHeld", 1'h0, rdv[EV_CODE])
    xfer(1'h1, ADDR_CTRL_B, 32'h48);
    xfer(1'h0, ADDR_EVENT, 32'h0);
    `CHK("lctResumed", 1'h1, rdv[EV_CODE])
    xfer(1'h1, ADDR_EVENT, 32'h7);
    // leave a test running so the join below has to abort it
    xfer(1'h1, ADDR_CTRL_B, 32'h8);
  endtask
  task automatic joinRing();
    xfer(1'h1, ADDR_CTRL_B, 32'h4);
    waitReg(ADDR_STATUS_B, 32'hF, 32'h8);
    `CHK("state", S_ACTIVE, rdv[3:0])
    `CHK("scJoin", 1'h1, scJoin)
    scrubDone <= 1'h1;
    @(posedge clk_sys);
    scrubDone <= 1'h0;
    xfer(1'h0, ADDR_EVENT, 32'h0);
    `CHK("enabled", 1'h1, rdv[EV_ENABLED])
    `CHK("lctAborted", 1'h0, rdv[EV_CODE])
  endtask
  task automatic noiseBreak();
    noiseReq <= 1'h1;
    repeat (20) @(posedge clk_sys);
    xfer(1'h0, ADDR_STATUS_B, 32'h0);
    `CHK("stillActive", S_ACTIVE, rdv[3:0])
    lineStateFlag <= 1'h1;
    waitReg(ADDR_STATUS_B, 32'hF, 32'h1);
    `CHK("cause", BC_NOISE, rdv[6:4])
    `CHK("lsf", 1'h1, rdv[ST_LSF])
    noiseReq <= 1'h0;
    repeat (80) @(posedge clk_sys);
    xfer(1'h0, ADDR_STATUS_B, 32'h0);
    `CHK("noRestart", S_BREAK, rdv[3:0])
    xfer(1'h1, ADDR_CTRL_B, {30'h0, CMD_STOP});
    xfer(1'h0, ADDR_STATUS_B, 32'h0);
    `CHK("stopped", S_OFF, rdv[3:0])
  endtask
  task automatic test_done();
    if (failCount == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    failCount++;
    test_done();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'h0;
    bootRegs();
    signalBits();
    resendBits();
    lctTest();
    joinRing();
    noiseBreak();
    test_done();
  end
endmodule // testbench
`default_nettype wire
